// File: wsam_wind_speed_alarm_monitor.sv
// wind speed alarm monitor top with axi4-lite status and event log
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module wsam_wind_speed_alarm_monitor #(
  parameter int unsigned TICK_CYCLES = wsam_pkg::TICK_CYCLES,
  parameter int unsigned LOSS_TICKS  = wsam_pkg::LOSS_TICKS
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        block_enable_in,
  input  wire logic        unit_select,
  input  wire logic [15:0] alarm_limit,
  input  wire logic [15:0] alert_limit,
  input  wire logic [15:0] gust_filter_delay,
  input  wire logic [15:0] wind_speed_in,
  input  wire logic        lamp_check_req,
  output logic             enable_status_out,
  output logic             amber_lamp,
  output logic             red_lamp_out,
  output logic             horn_out,
  output logic             alarm_active,
  output logic [15:0]      fault_code,
  output logic [10:0][31:0] alarm_event_log,
  output logic             irq,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  logic [22:0] tick_cnt_q;
  logic        tick_q;
  logic [31:0] time_q;
  logic [15:0] speed_prev_q;
  logic [18:0] loss_cnt_q;
  logic        loss_q;
  logic [15:0] alarm_lim_c;
  logic [15:0] alert_lim_c;
  logic [15:0] alarm_max_c;
  logic [15:0] alert_max_c;
  logic [7:0]  delay_c;
  logic        alarm_filt;
  logic        alert_filt;
  logic        alarm_c;
  logic        alert_c;
  logic        clamp_alarm_c;
  logic        clamp_alert_c;
  logic        lamp_prev_q;
  logic        test_on_q;
  logic [6:0]  test_cnt_q;
  logic        phase_q;
  logic [6:0]  blink_cnt_q;
  logic        en_q;
  logic        amber_q;
  logic        red_q;
  logic        horn_q;
  logic        alarm_q;
  logic [15:0] fault_q;
  logic [10:0][31:0] log_q;
  logic        log_event_c;
  logic [3:0]  ev_prev_q;
  logic [3:0]  ev_cur_c;
  logic [3:0]  irq_status_q;
  logic [3:0]  irq_en_q;
  logic [3:0]  irq_clr_c;
  logic        irq_q;
  logic        awready_q;
  logic        wready_q;
  logic        aw_full_q;
  logic        w_full_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        do_write_c;
  logic [31:0] rd_data_c;
  logic        rd_ok_c;

  // fixed 0.1 s time base shared by every delay
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_q <= 23'h000000;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == 23'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= 23'h000000;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 23'h000001;
      tick_q     <= 1'b0;
    end
  end

  // time stamp in 0.1 s units; software may preset it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      time_q <= 32'h00000000;
    end else if (do_write_c && awaddr_q == wsam_pkg::ADDR_TIME) begin
      time_q <= wsam_pkg::apply_strb(time_q, wdata_q, wstrb_q);
    end else if (tick_q) begin
      time_q <= time_q + 32'h00000001;
    end
  end

  // any change of the speed word counts as a sign of life
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      speed_prev_q <= 16'h0000;
      loss_cnt_q   <= 19'h00000;
      loss_q       <= 1'b0;
    end else begin
      speed_prev_q <= wind_speed_in;
      if (wind_speed_in != speed_prev_q) begin
        loss_cnt_q <= 19'h00000;
        loss_q     <= 1'b0;
      end else if (tick_q && !loss_q) begin
        if (loss_cnt_q == 19'(LOSS_TICKS)) begin
          loss_q <= 1'b1;
        end else begin
          loss_cnt_q <= loss_cnt_q + 19'h00001;
        end
      end
    end
  end

  assign alarm_max_c = unit_select ? wsam_pkg::ALARM_MAX_MPH
                                   : wsam_pkg::ALARM_MAX_KMH;
  assign alert_max_c = unit_select ? wsam_pkg::ALERT_MAX_MPH
                                   : wsam_pkg::ALERT_MAX_KMH;
  assign alarm_lim_c   = wsam_pkg::clamp16(alarm_limit, alarm_max_c);
  assign alert_lim_c   = wsam_pkg::clamp16(alert_limit, alert_max_c);
  assign clamp_alarm_c = alarm_limit > alarm_max_c;
  assign clamp_alert_c = alert_limit > alert_max_c;
  // an oversize delay is held at the top of its range, not rejected
  assign delay_c = 8'(wsam_pkg::clamp16(gust_filter_delay,
                                        wsam_pkg::FILTER_MAX));

  wsam_gust_filter u_alarm_filter (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick_q),
    .above   (wind_speed_in > alarm_lim_c),
    .delay   (delay_c),
    .active  (alarm_filt)
  );

  wsam_gust_filter u_alert_filter (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick_q),
    .above   (wind_speed_in > alert_lim_c),
    .delay   (delay_c),
    .active  (alert_filt)
  );

  assign alarm_c = alarm_filt || loss_q;
  assign alert_c = alert_filt;

  // lamp test runs on the request edge, not its level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lamp_prev_q <= 1'b0;
      test_on_q   <= 1'b0;
      test_cnt_q  <= 7'h00;
    end else begin
      lamp_prev_q <= lamp_check_req;
      if (lamp_check_req && !lamp_prev_q) begin
        test_on_q  <= 1'b1;
        test_cnt_q <= 7'h00;
      end else if (test_on_q && tick_q) begin
        if (test_cnt_q == 7'(wsam_pkg::LAMP_TEST_TICKS - 1)) begin
          test_on_q <= 1'b0;
        end else begin
          test_cnt_q <= test_cnt_q + 7'h01;
        end
      end
    end
  end

  // blink phase restarts lit whenever an alert begins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q     <= 1'b1;
      blink_cnt_q <= 7'h00;
    end else if (!alert_c) begin
      phase_q     <= 1'b1;
      blink_cnt_q <= 7'h00;
    end else if (tick_q) begin
      if (blink_cnt_q == 7'(wsam_pkg::BLINK_TICKS - 1)) begin
        blink_cnt_q <= 7'h00;
        phase_q     <= !phase_q;
      end else begin
        blink_cnt_q <= blink_cnt_q + 7'h01;
      end
    end
  end

  // indicator outputs; disable overrides lamp test and alarms alike
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_q    <= 1'b0;
      amber_q <= 1'b0;
      red_q   <= 1'b0;
      horn_q  <= 1'b0;
      alarm_q <= 1'b0;
      fault_q <= 16'h0000;
    end else if (!block_enable_in) begin
      en_q    <= 1'b0;
      amber_q <= 1'b0;
      red_q   <= 1'b0;
      horn_q  <= 1'b0;
      alarm_q <= 1'b0;
      fault_q <= 16'h0000;
    end else begin
      en_q    <= 1'b1;
      amber_q <= test_on_q || alarm_c || (alert_c && phase_q);
      red_q   <= test_on_q || alarm_c;
      horn_q  <= test_on_q || alarm_c || (alert_c && phase_q);
      alarm_q <= alarm_c;
      fault_q <= 16'h0000;
      fault_q[wsam_pkg::FAULT_LOSS_BIT]  <= loss_q;
      fault_q[wsam_pkg::FAULT_ALERT_BIT] <= clamp_alert_c;
      fault_q[wsam_pkg::FAULT_ALARM_BIT] <= clamp_alarm_c;
    end
  end

  assign log_event_c = block_enable_in && alarm_c && !alarm_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      log_q <= '0;
    end else if (log_event_c) begin
      log_q <= {log_q[9:0], time_q};
    end
  end

  // interrupt status: set beats a clear in the same cycle
  assign ev_cur_c  = {clamp_alarm_c || clamp_alert_c, loss_q,
                      alert_c, alarm_c};
  assign irq_clr_c = (do_write_c && awaddr_q == wsam_pkg::ADDR_IRQ_CLEAR &&
                      wstrb_q[0]) ? wdata_q[3:0] : 4'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_prev_q    <= 4'h0;
      irq_status_q <= 4'h0;
      irq_en_q     <= wsam_pkg::IRQ_ENABLE_RST;
      irq_q        <= 1'b0;
    end else begin
      ev_prev_q    <= ev_cur_c;
      irq_status_q <= (irq_status_q & ~irq_clr_c) | (ev_cur_c & ~ev_prev_q);
      if (do_write_c && awaddr_q == wsam_pkg::ADDR_IRQ_ENABLE &&
          wstrb_q[0]) begin
        irq_en_q <= wdata_q[3:0];
      end
      irq_q <= |(irq_status_q & irq_en_q);
    end
  end

  // write channel: address and data latched independently
  assign do_write_c = aw_full_q && w_full_q && !bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= wsam_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        awaddr_q  <= s_axi_awaddr;
        aw_full_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q) begin
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
        w_full_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (do_write_c) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= (awaddr_q == wsam_pkg::ADDR_IRQ_CLEAR ||
                      awaddr_q == wsam_pkg::ADDR_IRQ_ENABLE ||
                      awaddr_q == wsam_pkg::ADDR_TIME) ?
                     wsam_pkg::RESP_OKAY : wsam_pkg::RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_data_c = 32'h00000000;
    rd_ok_c   = 1'b1;
    if (s_axi_araddr >= wsam_pkg::ADDR_LOG_BASE &&
        s_axi_araddr < wsam_pkg::ADDR_LOG_BASE + 8'h2C &&
        s_axi_araddr[1:0] == 2'h0) begin
      rd_data_c = log_q[4'((s_axi_araddr - wsam_pkg::ADDR_LOG_BASE) >> 2)];
    end else begin
      unique case (s_axi_araddr)
        wsam_pkg::ADDR_IRQ_STATUS: rd_data_c = {28'h0000000, irq_status_q};
        wsam_pkg::ADDR_IRQ_CLEAR:  rd_data_c = 32'h00000000;
        wsam_pkg::ADDR_IRQ_ENABLE: rd_data_c = {28'h0000000, irq_en_q};
        wsam_pkg::ADDR_STATE: begin
          rd_data_c[15:0] = fault_q;
          rd_data_c[wsam_pkg::STATE_ALERT_BIT] = alert_c;
          rd_data_c[wsam_pkg::STATE_ALARM_BIT] = alarm_c;
          rd_data_c[wsam_pkg::STATE_TEST_BIT]  = test_on_q;
        end
        wsam_pkg::ADDR_TIME:       rd_data_c = time_q;
        default:                   rd_ok_c   = 1'b0;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= wsam_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_data_c;
      rresp_q   <= rd_ok_c ? wsam_pkg::RESP_OKAY : wsam_pkg::RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign enable_status_out = en_q;
  assign amber_lamp        = amber_q;
  assign red_lamp_out      = red_q;
  assign horn_out          = horn_q;
  assign alarm_active      = alarm_q;
  assign fault_code        = fault_q;
  assign alarm_event_log   = log_q;
  assign irq               = irq_q;
  assign s_axi_awready     = awready_q;
  assign s_axi_wready      = wready_q;
  assign s_axi_bvalid      = bvalid_q;
  assign s_axi_bresp       = bresp_q;
  assign s_axi_arready     = arready_q;
  assign s_axi_rvalid      = rvalid_q;
  assign s_axi_rdata       = rdata_q;
  assign s_axi_rresp       = rresp_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_disable_forces_low: assert property (
    !block_enable_in |=> !enable_status_out && !amber_lamp && !red_lamp_out &&
                         !horn_out && !alarm_active && fault_code == 16'h0000)
    else $error("outputs not in fallback while disabled");

  // the reset term keeps the release edge itself out of the check
  a_enable_resumes: assert property (
    aresetn && block_enable_in |=> enable_status_out)
    else $error("enable status did not follow enable input");

  a_alarm_limit_clamp: assert property (
    alarm_lim_c <= (unit_select ? 16'h002D : 16'h0048))
    else $error("alarm limit above unit maximum");

  a_alert_limit_clamp: assert property (
    alert_lim_c <= (unit_select ? 16'h001F : 16'h0032))
    else $error("alert limit above unit maximum");

  a_clamp_flag: assert property (
    block_enable_in && alarm_limit > alarm_max_c |=>
      fault_code[2] || !$past(block_enable_in, 1))
    else $error("alarm clamp not reported");

  a_loss_alarm: assert property (
    block_enable_in && loss_q |=> alarm_active && fault_code[0])
    else $error("signal loss not raised as alarm");

  a_delay_range: assert property (
    delay_c <= 8'hC8)
    else $error("filter delay above range");

  a_lamp_test_on: assert property (
    $rose(lamp_check_req) |=> test_on_q ##1
      (amber_lamp && red_lamp_out && horn_out || !$past(block_enable_in)))
    else $error("lamp test did not light every indicator");

  a_quiet_dark: assert property (
    block_enable_in && !alert_c && !alarm_c && !test_on_q |=>
      !amber_lamp && !horn_out)
    else $error("indicator on with no alert");

  a_alarm_steady: assert property (
    block_enable_in && alarm_c |=> amber_lamp && red_lamp_out && horn_out)
    else $error("alarm indication not steady");

  a_red_off_calm: assert property (
    block_enable_in && !alarm_c && !test_on_q |=> !red_lamp_out)
    else $error("red lamp on without alarm");

  a_log_newest: assert property (
    log_event_c |=> alarm_event_log[0] == $past(time_q))
    else $error("newest log entry not the alarm time");

  a_tick_single: assert property (
    tick_q |=> !tick_q)
    else $error("time base tick longer than one cycle");

  c_alarm_raised: cover property (block_enable_in ##1 $rose(alarm_active));
  c_alert_blink:  cover property (alert_c && $fell(phase_q));
  c_lamp_test:    cover property ($fell(test_on_q));
  c_axi_write:    cover property (do_write_c && irq_clr_c != 4'h0);

endmodule : wsam_wind_speed_alarm_monitor

// File: wsam_pkg.sv
// constants, types and helpers of the wind speed alarm monitor
package wsam_pkg;

  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned TICK_MS     = 100;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  localparam int unsigned LAMP_TEST_S     = 6;
  localparam int unsigned LAMP_TEST_TICKS = LAMP_TEST_S * 1000 / TICK_MS;
  localparam int unsigned BLINK_S         = 6;
  localparam int unsigned BLINK_TICKS     = BLINK_S * 1000 / TICK_MS;
  localparam int unsigned LOSS_HOURS      = 8;
  localparam int unsigned LOSS_TICKS      = LOSS_HOURS * 3600 * 1000 / TICK_MS;

  localparam logic [15:0] ALARM_MAX_KMH  = 16'h0048;
  localparam logic [15:0] ALARM_MAX_MPH  = 16'h002D;
  localparam logic [15:0] ALERT_MAX_KMH  = 16'h0032;
  localparam logic [15:0] ALERT_MAX_MPH  = 16'h001F;
  localparam logic [15:0] FILTER_MAX     = 16'h00C8;
  localparam logic [15:0] FILTER_DEFAULT = 16'h0032;

  localparam int unsigned FAULT_LOSS_BIT  = 0;
  localparam int unsigned FAULT_ALERT_BIT = 1;
  localparam int unsigned FAULT_ALARM_BIT = 2;

  localparam int unsigned LOG_DEPTH = 11;
  localparam int unsigned TS_W      = 32;

  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h00;
  localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h04;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h08;
  localparam logic [7:0] ADDR_STATE      = 8'h0C;
  localparam logic [7:0] ADDR_TIME       = 8'h10;
  localparam logic [7:0] ADDR_LOG_BASE   = 8'h40;

  localparam int unsigned IRQ_ALARM = 0;
  localparam int unsigned IRQ_ALERT = 1;
  localparam int unsigned IRQ_LOSS  = 2;
  localparam int unsigned IRQ_CLAMP = 3;
  localparam int unsigned IRQ_W     = 4;
  localparam logic [3:0]  IRQ_ENABLE_RST = 4'h0;

  localparam int unsigned STATE_ALERT_BIT = 16;
  localparam int unsigned STATE_ALARM_BIT = 17;
  localparam int unsigned STATE_TEST_BIT  = 18;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    FILT_OFF,
    FILT_ARMING,
    FILT_ON,
    FILT_RELEASING
  } wsam_filt_state_type;

  function automatic logic [15:0] clamp16(input logic [15:0] v,
                                          input logic [15:0] lim);
    return (v > lim) ? lim : v;
  endfunction : clamp16

  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : apply_strb

endpackage : wsam_pkg

// File: wsam_gust_filter.sv
// gust filter: qualifies a limit crossing over a delay in both directions
`timescale 1ns/1ps
module wsam_gust_filter (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       tick,
  input  wire logic       above,
  input  wire logic [7:0] delay,
  output logic            active
);

  wsam_pkg::wsam_filt_state_type state_q;
  wsam_pkg::wsam_filt_state_type state_d;
  logic [7:0]                    cnt_q;
  logic [7:0]                    cnt_d;
  logic                          active_q;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    unique case (state_q)
      wsam_pkg::FILT_OFF: begin
        if (above) begin
          cnt_d   = 8'h00;
          state_d = (delay == 8'h00) ? wsam_pkg::FILT_ON
                                     : wsam_pkg::FILT_ARMING;
        end
      end
      wsam_pkg::FILT_ARMING: begin
        // a dip below the limit restarts the whole delay
        if (!above) begin
          state_d = wsam_pkg::FILT_OFF;
        end else if (tick) begin
          if (cnt_q + 8'h01 >= delay) begin
            state_d = wsam_pkg::FILT_ON;
          end else begin
            cnt_d = cnt_q + 8'h01;
          end
        end
      end
      wsam_pkg::FILT_ON: begin
        if (!above) begin
          cnt_d   = 8'h00;
          state_d = (delay == 8'h00) ? wsam_pkg::FILT_OFF
                                     : wsam_pkg::FILT_RELEASING;
        end
      end
      wsam_pkg::FILT_RELEASING: begin
        if (above) begin
          state_d = wsam_pkg::FILT_ON;
        end else if (tick) begin
          if (cnt_q + 8'h01 >= delay) begin
            state_d = wsam_pkg::FILT_OFF;
          end else begin
            cnt_d = cnt_q + 8'h01;
          end
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q  <= wsam_pkg::FILT_OFF;
      cnt_q    <= 8'h00;
      active_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      active_q <= (state_d == wsam_pkg::FILT_ON) ||
                  (state_d == wsam_pkg::FILT_RELEASING);
    end
  end

  assign active = active_q;

  a_rise_needs_above: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(active_q) |-> $past(above))
    else $error("filter asserted while speed was below limit");

  a_fall_needs_below: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $fell(active_q) |-> !$past(above))
    else $error("filter withdrew while speed was above limit");

endmodule : wsam_gust_filter

// File: wsam_anemo_model.sv
// stand-in for the anemometer scaling stage feeding the speed word
`timescale 1ns/1ps
module wsam_anemo_model (
  input  wire logic        aclk,
  input  wire logic        live,
  input  wire logic [15:0] speed,
  output logic      [15:0] wind_speed_in
);
  logic wobble_q;
  initial begin
    wobble_q = 1'b0;
    wind_speed_in = 16'h0000;
  end
  // lsb wobble keeps the signal alive; freezing it fakes a dead sensor
  always @(posedge aclk) begin
    if (live) begin
      wobble_q <= ~wobble_q;
    end
    wind_speed_in <= speed ^ {15'h0000, wobble_q};
  end
endmodule : wsam_anemo_model

// File: wind_speed_alarm_monitor_test.sv
// self-checking bench for the wind speed alarm monitor
`timescale 1ns/1ps
module wind_speed_alarm_monitor_test;
  logic aclk, aresetn, block_enable_in, unit_select, lamp_check_req, live;
  logic [15:0] alarm_limit, alert_limit, gust_filter_delay, wind_speed_in;
  logic [15:0] spd, fault_code;
  logic enable_status_out, amber_lamp, red_lamp_out, horn_out;
  logic alarm_active, irq;
  logic [10:0][31:0] alarm_event_log;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, old;
  logic [3:0] s_axi_wstrb, ind;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  assign ind = {amber_lamp, red_lamp_out, horn_out, alarm_active};
  wsam_wind_speed_alarm_monitor #(.TICK_CYCLES(10), .LOSS_TICKS(20)) DUT (.*);
  wsam_anemo_model anemo (.aclk(aclk), .live(live), .speed(spd),
                          .wind_speed_in(wind_speed_in));
  initial aclk = 1'b0;
  always #10 aclk = ~aclk;
  task automatic results;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic w(input int n);
    repeat (n) @(posedge aclk);
  endtask : w
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr
  task automatic t_regs;
    // preset time stamp so every later log entry is clearly non-zero
    axw(wsam_pkg::ADDR_TIME, 32'h00000100);
    chk({30'h0, br}, {30'h0, wsam_pkg::RESP_OKAY});
    axr(wsam_pkg::ADDR_TIME);
    chk(rd & 32'hFFFFFFF0, 32'h00000100);
    axw(wsam_pkg::ADDR_STATE, 32'h00000000);
    chk({30'h0, br}, {30'h0, wsam_pkg::RESP_SLVERR});
    axr(wsam_pkg::ADDR_IRQ_ENABLE);
    chk(rd, 32'h00000000);
    axr(8'h20);
    chk({30'h0, rr}, {30'h0, wsam_pkg::RESP_SLVERR});
  endtask : t_regs
  task automatic t_alarm;
    spd <= 16'h003C;
    w(10);
    chk({28'h0, ind}, 32'hF);
    chk({31'h0, irq}, 32'h0);
    axw(wsam_pkg::ADDR_IRQ_ENABLE, 32'h1);
    w(3);
    chk({31'h0, irq}, 32'h1);
    axr(wsam_pkg::ADDR_IRQ_STATUS);
    chk({31'h0, rd[0]}, 32'h1);
    axw(wsam_pkg::ADDR_IRQ_CLEAR, 32'h1);
    w(3);
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, alarm_event_log[0] >= 32'h00000100}, 32'h1);
    spd <= 16'h0000;
    w(10);
    chk({30'h0, red_lamp_out, alarm_active}, 32'h0);
  endtask : t_alarm
  task automatic t_gust;
    gust_filter_delay <= 16'h0005;
    spd <= 16'h003C;
    w(20);
    spd <= 16'h0000;
    w(80);
    chk({31'h0, alarm_active}, 32'h0);
    spd <= 16'h003C;
    w(30);
    chk({31'h0, alarm_active}, 32'h0);
    w(40);
    chk({31'h0, alarm_active}, 32'h1);
    spd <= 16'h0000;
    w(20);
    chk({31'h0, alarm_active}, 32'h1);
    w(60);
    chk({31'h0, alarm_active}, 32'h0);
    gust_filter_delay <= 16'h0000;
  endtask : t_gust
  task automatic t_alert;
    spd <= 16'h0023;
    w(10);
    chk({28'h0, ind}, 32'hA);
    w(700);
    chk({28'h0, ind}, 32'h0);
    spd <= 16'h0000;
    w(10);
  endtask : t_alert
  task automatic lim(input logic u, input logic [15:0] al, at, sp,
                     input logic [3:0] e);
    unit_select <= u;
    alarm_limit <= al;
    alert_limit <= at;
    spd <= sp;
    w(6);
    chk({28'h0, fault_code[2:0], alarm_active}, {28'h0, e});
  endtask : lim
  task automatic t_clamp;
    lim(1'b0, 16'h0064, 16'h0064, 16'h004A, 4'hD);
    lim(1'b0, 16'h0064, 16'h0064, 16'h0047, 4'hC);
    lim(1'b1, 16'h0064, 16'h0064, 16'h002E, 4'hD);
    lim(1'b1, 16'h002D, 16'h001F, 16'h002D, 4'h0);
    lim(1'b0, 16'h0028, 16'h001E, 16'h0000, 4'h0);
  endtask : t_clamp
  task automatic t_disable;
    spd <= 16'h003C;
    w(6);
    old = alarm_event_log[0];
    block_enable_in <= 1'b0;
    w(3);
    chk({11'h0, fault_code, enable_status_out, amber_lamp, red_lamp_out,
         horn_out, alarm_active}, 32'h0);
    chk(alarm_event_log[0], old);
    block_enable_in <= 1'b1;
    w(4);
    chk({11'h0, fault_code, enable_status_out, amber_lamp, red_lamp_out,
         horn_out, alarm_active}, 32'h1F);
    spd <= 16'h0000;
    w(6);
  endtask : t_disable
  task automatic t_lamp;
    lamp_check_req <= 1'b1;
    w(5);
    chk({29'h0, amber_lamp, red_lamp_out, horn_out}, 32'h7);
    w(500);
    chk({29'h0, amber_lamp, red_lamp_out, horn_out}, 32'h7);
    w(150);
    chk({29'h0, amber_lamp, red_lamp_out, horn_out}, 32'h0);
    lamp_check_req <= 1'b0;
  endtask : t_lamp
  task automatic t_loss;
    old = alarm_event_log[0];
    live <= 1'b0;
    w(260);
    chk({30'h0, fault_code[0], alarm_active}, 32'h3);
    chk(alarm_event_log[1], old);
    live <= 1'b1;
    w(10);
    chk({16'h0, fault_code}, 32'h0);
  endtask : t_loss
  initial begin
    {aresetn, unit_select, lamp_check_req, s_axi_awvalid} = 4'h0;
    {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 4'h0;
    {block_enable_in, live} = 2'h3;
    {alarm_limit, alert_limit} = {16'h0028, 16'h001E};
    {gust_filter_delay, spd} = 32'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    w(16);
    aresetn <= 1'b1;
    w(2);
    t_regs();
    t_alarm();
    t_gust();
    t_alert();
    t_clamp();
    t_disable();
    t_lamp();
    t_loss();
    results();
  end
endmodule : wind_speed_alarm_monitor_test
